// ### irq_pkg.sv
package irq_pkg;

    localparam int          NUM_SRC         = 17;
    localparam int          IDX_W           = 5;
    localparam logic [15:0] VEC_RESET       = 16'h0000;
    localparam logic [15:0] VEC_BASE        = 16'h0003;
    localparam logic [15:0] VEC_STRIDE      = 16'h0008;

    // AXI byte addresses of the registers
    localparam logic [7:0]  ADDR_ENABLE     = 8'hA8;
    localparam logic [7:0]  ADDR_LEVEL      = 8'hB8;
    localparam logic [7:0]  ADDR_PEND       = 8'hC0;
    localparam logic [7:0]  ADDR_STATUS     = 8'hC4;

    localparam logic [7:0]  ENABLE_RESET    = 8'h00;
    localparam logic [7:0]  LEVEL_RESET     = 8'h80;

    // bit positions in the enable and level registers
    localparam int          BIT_GATE        = 7;
    localparam int          BIT_SPI         = 6;
    localparam int          BIT_TIMER2      = 5;
    localparam int          BIT_UART0       = 4;
    localparam int          BIT_TIMER1      = 3;
    localparam int          BIT_EXT1        = 2;
    localparam int          BIT_TIMER0      = 1;
    localparam int          BIT_EXT0        = 0;
    localparam int          BIT_LEVEL_FIXED = 7;

    // source order indexes; hardware clears only 0 to 3 on vectoring
    localparam int          SRC_EXT0        = 0;
    localparam int          SRC_TIMER0      = 1;
    localparam int          SRC_EXT1        = 2;
    localparam int          SRC_TIMER1      = 3;
    localparam int          SRC_UART0       = 4;
    localparam int          SRC_TIMER2      = 5;
    localparam int          SRC_SPI         = 6;

    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef struct packed {
        logic        valid;
        logic        high;
        logic [4:0]  index;
    } winner_t;

    typedef enum logic [1:0] {
        LVL_NONE,
        LVL_LOW,
        LVL_HIGH
    } level_t;

endpackage

// ### irq_prio_pick.sv
`timescale 1ns/1ns
`default_nettype none
module irq_prio_pick
(
    // requests already gated and their level bits
    input  wire logic [16:0]     req,
    input  wire logic [16:0]     high,
    // winner
    output irq_pkg::winner_t     win
);
    import irq_pkg::*;

    function automatic winner_t pick(input logic [16:0] r);
        winner_t w;
        w = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (r[i])
            begin
                w.valid = 1'b1;
                w.index = IDX_W'(i);
            end
        end
        return w;
    endfunction

    winner_t w_hi;
    winner_t w_lo;

    always_comb
    begin
        w_hi = pick(req & high);
        w_lo = pick(req & ~high);
        // high level first, lower index breaks ties
        if (w_hi.valid)
        begin
            win      = w_hi;
            win.high = 1'b1;
        end
        else
        begin
            win = w_lo;
        end
    end
endmodule
`default_nettype wire

// ### irq_regs.sv
`timescale 1ns/1ns
`default_nettype none
module irq_regs
(
    // clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // write address and data
    input  wire logic [7:0]      awaddr,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    // read
    input  wire logic [7:0]      araddr,
    input  wire logic            arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  wire logic            rready,
    // state shown to software
    input  wire logic [16:0]     pend_view,
    input  wire logic [7:0]      status_view,
    // register values
    output logic [7:0]           enable_bits,
    output logic [6:0]           level_bits,
    output logic                 pend_wr,
    output logic [16:0]          pend_wdata
);
    import irq_pkg::*;

    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic       w_lane;
    logic [16:0] w_word;
    logic       do_write;

    assign awready  = ~aw_held & ~bvalid;
    assign wready   = ~w_held & ~bvalid;
    assign arready  = ~rvalid;
    assign do_write = aw_held & w_held & ~bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_byte  <= 8'h00;
            w_lane  <= 1'b0;
            w_word  <= 17'h00000;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            else if (do_write)
            begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_byte <= wdata[7:0];
                w_lane <= wstrb[0];
                w_word <= wdata[16:0];
            end
            else if (do_write)
            begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid <= 1'b1;
            bresp  <= (aw_addr == ADDR_ENABLE || aw_addr == ADDR_LEVEL ||
                       aw_addr == ADDR_PEND) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_bits <= ENABLE_RESET;
            level_bits  <= LEVEL_RESET[6:0];
        end
        else if (do_write && w_lane)
        begin
            if (aw_addr == ADDR_ENABLE)
            begin
                enable_bits <= w_byte;
            end
            // top bit of the level register is not stored
            if (aw_addr == ADDR_LEVEL)
            begin
                level_bits <= w_byte[6:0];
            end
        end
    end

    // pending write lets software raise any source by hand
    assign pend_wr    = do_write && (aw_addr == ADDR_PEND);
    assign pend_wdata = w_word;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            case (araddr)
                ADDR_ENABLE: rdata <= {24'h000000, enable_bits};
                ADDR_LEVEL: rdata <= {24'h000000, 1'b1, level_bits};
                ADDR_PEND:   rdata <= {15'h0000, pend_view};
                ADDR_STATUS: rdata <= {24'h000000, status_view};
                default:
                begin
                    rdata <= 32'h00000000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### two_level_vectored_irq_ctrl.sv
// Overview of operation
// - global gate low blocks every request
// - with gate high, sources 0-6 each need enable; 7-16 pass
// - bit 6 gates spi requests
// - bit 5 gates both timer 2 flags
// - bit 4 gates uart0 requests
// - bits 3 and 1 gate timer1/timer0
// - bits 2 and 0 gate ext1/ext0
// - level bits 0-6 select high priority
// - level bit 7 reads one, ignores writes
// - vectors 0x0003 plus 8*index, lower index wins within a level
// - hardware clears only ext and timer0/1 flags
// - flags set even while source disabled
// - high preempts low; equal waits for return
// - requests sampled and decoded every clock
// - still-pending flag re-requests after return
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module two_level_vectored_irq_ctrl
(
    // clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // axi4-lite write
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // external request pins, already conditioned as active high
    input  wire logic            ext_request_0,
    input  wire logic            ext_request_1,
    // peripheral flag set pulses, same clock
    input  wire logic            timer0_overflow_flag,
    input  wire logic            timer1_overflow_flag,
    // level flags held by peripherals, index 4 upward
    input  wire logic            uart0_flag,
    input  wire logic            timer2_high_overflow,
    input  wire logic            timer2_low_overflow,
    input  wire logic            spi_flag,
    input  wire logic [9:0]      ext_src_flags,
    // core side
    output logic                 irq_request,
    output logic [15:0]          irq_vector,
    input  wire logic            vector_call,
    input  wire logic            return_from_isr,
    // software clear of latched flags 0..3, pulse per bit
    input  wire logic [3:0]      flag_clear
);
    import irq_pkg::*;

    logic [1:0]  ext0_sync;
    logic [1:0]  ext1_sync;
    logic        ext0_prev;
    logic        ext1_prev;
    logic        ext0_edge;
    logic        ext1_edge;
    logic        ext0_pending;
    logic        ext1_pending;
    logic        tmr0_pend;
    logic        tmr1_pend;
    logic        sw_pend_wr;
    logic [16:0] sw_pend_data;
    logic [16:0] sw_pend;
    logic [16:0] pending;
    logic [16:0] src_en;
    logic [16:0] src_high;
    logic [16:0] gated;
    logic [16:0] eligible;
    logic [7:0]  enable_bits;
    logic [6:0]  level_bits;
    logic        global_irq_gate;
    logic        spi_irq_en;
    logic        timer2_irq_en;
    logic        uart0_irq_en;
    logic        timer1_irq_en;
    logic        ext1_irq_en;
    logic        timer0_irq_en;
    logic        ext0_irq_en;
    logic        low_active;
    logic        high_active;
    logic        granted_high;
    logic [4:0]  granted_index;
    logic [4:0]  offer_index;
    logic        take;
    winner_t     win;
    level_t      level_now;
    logic [7:0]  status_view;

    // two flip-flops before anything looks at the pins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext0_sync <= 2'b00;
            ext1_sync <= 2'b00;
            ext0_prev <= 1'b0;
            ext1_prev <= 1'b0;
        end
        else
        begin
            ext0_sync <= {ext0_sync[0], ext_request_0};
            ext1_sync <= {ext1_sync[0], ext_request_1};
            ext0_prev <= ext0_sync[1];
            ext1_prev <= ext1_sync[1];
        end
    end

    assign ext0_edge = ext0_sync[1] & ~ext0_prev;
    assign ext1_edge = ext1_sync[1] & ~ext1_prev;

    assign take = vector_call & irq_request;

    // latched flags: set wins over any clear in the same cycle
    // flags latch regardless of enable state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext0_pending <= 1'b0;
            ext1_pending <= 1'b0;
            tmr0_pend    <= 1'b0;
            tmr1_pend    <= 1'b0;
        end
        else
        begin
            if (ext0_edge || (sw_pend_wr && sw_pend_data[SRC_EXT0]))
                ext0_pending <= 1'b1;
            else if (flag_clear[SRC_EXT0] ||
                     (take && offer_index == 5'(SRC_EXT0)))
                ext0_pending <= 1'b0;
            if (ext1_edge || (sw_pend_wr && sw_pend_data[SRC_EXT1]))
                ext1_pending <= 1'b1;
            else if (flag_clear[SRC_EXT1] ||
                     (take && offer_index == 5'(SRC_EXT1)))
                ext1_pending <= 1'b0;
            if (timer0_overflow_flag ||
                (sw_pend_wr && sw_pend_data[SRC_TIMER0]))
                tmr0_pend <= 1'b1;
            else if (flag_clear[SRC_TIMER0] ||
                     (take && offer_index == 5'(SRC_TIMER0)))
                tmr0_pend <= 1'b0;
            if (timer1_overflow_flag ||
                (sw_pend_wr && sw_pend_data[SRC_TIMER1]))
                tmr1_pend <= 1'b1;
            else if (flag_clear[SRC_TIMER1] ||
                     (take && offer_index == 5'(SRC_TIMER1)))
                tmr1_pend <= 1'b0;
        end
    end

    // software-set bits for the peripheral-owned sources stay until
    // software writes zero; hardware never clears them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sw_pend <= 17'h00000;
        else if (sw_pend_wr)
            sw_pend <= {sw_pend_data[16:4], 4'h0};
    end

    assign pending = {ext_src_flags,
                      spi_flag,
                      timer2_high_overflow | timer2_low_overflow,
                      uart0_flag,
                      tmr1_pend, ext1_pending, tmr0_pend, ext0_pending}
                     | sw_pend;

    assign global_irq_gate = enable_bits[BIT_GATE];
    assign spi_irq_en      = enable_bits[BIT_SPI];
    assign timer2_irq_en   = enable_bits[BIT_TIMER2];
    assign uart0_irq_en    = enable_bits[BIT_UART0];
    assign timer1_irq_en   = enable_bits[BIT_TIMER1];
    assign ext1_irq_en     = enable_bits[BIT_EXT1];
    assign timer0_irq_en   = enable_bits[BIT_TIMER0];
    assign ext0_irq_en     = enable_bits[BIT_EXT0];

    // extended sources have no enable register here, so pass them
    assign src_en = {10'h3FF, spi_irq_en, timer2_irq_en, uart0_irq_en,
                     timer1_irq_en, ext1_irq_en, timer0_irq_en,
                     ext0_irq_en};
    assign src_high = {10'h000, level_bits};

    assign gated = global_irq_gate ? (pending & src_en)
                                   : 17'h00000;

    // only levels above the active one may be presented
    always_comb
    begin
        if (high_active)
            eligible = 17'h00000;
        else if (low_active)
            eligible = gated & src_high;
        else
            eligible = gated;
    end

    irq_prio_pick u_pick
    (
        .req  (eligible),
        .high (src_high),
        .win  (win)
    );

    // decoded every clock; request registered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_request <= 1'b0;
            irq_vector  <= VEC_RESET;
            offer_index <= 5'h00;
        end
        else if (take)
        begin
            irq_request <= 1'b0;
        end
        else
        begin
            irq_request <= win.valid;
            // kept with the vector: a newer winner must not steal the call
            offer_index <= win.index;
            irq_vector  <= VEC_BASE +
                           VEC_STRIDE * {11'h000, win.index};
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            granted_high  <= 1'b0;
            granted_index <= 5'h00;
        end
        else if (take)
        begin
            granted_high  <= src_high[offer_index];
            granted_index <= offer_index;
        end
    end

    // active level stack: two levels, return pops the top
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_active  <= 1'b0;
            high_active <= 1'b0;
        end
        else if (take)
        begin
            if (src_high[offer_index])
                high_active <= 1'b1;
            else
                low_active <= 1'b1;
        end
        else if (return_from_isr)
        begin
            // relies on core reporting each return
            if (high_active)
                high_active <= 1'b0;
            else
                low_active <= 1'b0;
        end
    end

    always_comb
    begin
        case ({high_active, low_active})
            2'b00:   level_now = LVL_NONE;
            2'b01:   level_now = LVL_LOW;
            default: level_now = LVL_HIGH;
        endcase
    end

    assign status_view = {1'b0, level_now, granted_high, granted_index[3:0]};

    irq_regs u_regs
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .awaddr      (s_axi_awaddr),
        .awvalid     (s_axi_awvalid),
        .awready     (s_axi_awready),
        .wdata       (s_axi_wdata),
        .wstrb       (s_axi_wstrb),
        .wvalid      (s_axi_wvalid),
        .wready      (s_axi_wready),
        .bresp       (s_axi_bresp),
        .bvalid      (s_axi_bvalid),
        .bready      (s_axi_bready),
        .araddr      (s_axi_araddr),
        .arvalid     (s_axi_arvalid),
        .arready     (s_axi_arready),
        .rdata       (s_axi_rdata),
        .rresp       (s_axi_rresp),
        .rvalid      (s_axi_rvalid),
        .rready      (s_axi_rready),
        .pend_view   (pending),
        .status_view (status_view),
        .enable_bits (enable_bits),
        .level_bits  (level_bits),
        .pend_wr     (sw_pend_wr),
        .pend_wdata  (sw_pend_data)
    );

    gate_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !global_irq_gate |=> !irq_request)
        else $error("request raised with gate off");

    need_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_request && !$past(take)) |->
        $past(src_en[win.index] && global_irq_gate))
        else $error("request without enable");

    spi_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pending == 17'h00040 && global_irq_gate && spi_irq_en &&
         !low_active && !high_active && !take)
        |=> irq_request)
        else $error("spi request not passed");

    vec_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (win.valid && !take) |=>
        irq_vector == 16'h0003 + 16'h0008 * {11'h000, $past(win.index)})
        else $error("wrong vector");

    level_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && $past(s_axi_araddr == ADDR_LEVEL &&
                               s_axi_arvalid && s_axi_arready))
        |-> s_axi_rdata[7])
        else $error("level bit 7 read zero");

    hw_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && offer_index == 5'(SRC_TIMER0) && !timer0_overflow_flag &&
         !(sw_pend_wr && sw_pend_data[SRC_TIMER0])) |=> !tmr0_pend)
        else $error("timer0 flag not cleared on vectoring");

    latch_dis_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (timer1_overflow_flag && !timer1_irq_en) |=> tmr1_pend)
        else $error("flag lost while disabled");

    no_nest_a: assert property (@(posedge aclk) disable iff (!aresetn)
        high_active |=> !irq_request)
        else $error("request during high service");

    re_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (return_from_isr && !high_active && low_active && !take &&
         gated != 17'h00000) |-> ##[1:2] irq_request)
        else $error("no re-request after return");

endmodule
`default_nettype wire

// ### core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // controller side
    input  wire logic irq_request,
    output logic      vector_call,
    output logic      return_from_isr,
    // bench control: take_en low stalls the call
    input  wire logic take_en,
    input  wire logic ret_req
);
    // one call per offer; a held request must not be taken twice
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vector_call     <= 1'b0;
            return_from_isr <= 1'b0;
        end
        else
        begin
            vector_call     <= irq_request && take_en &&
                               !vector_call;
            return_from_isr <= ret_req;
        end
    end
endmodule
`default_nettype wire

// ### two_level_vectored_irq_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module two_level_vectored_irq_ctrl_tb;
    import irq_pkg::*;
    logic        aclk, aresetn, take, ret_req, timer2_low_overflow;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, irq_request, vector_call;
    logic        return_from_isr;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [15:0] irq_vector;
    logic [6:0]  src;
    logic [9:0]  ext_src_flags;
    int          bad_count, num_checks;

    two_level_vectored_irq_ctrl uut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready,
        .ext_request_0(src[0]), .timer0_overflow_flag(src[1]),
        .ext_request_1(src[2]), .timer1_overflow_flag(src[3]),
        .uart0_flag(src[4]), .timer2_high_overflow(src[5]),
        .spi_flag(src[6]), .timer2_low_overflow, .ext_src_flags,
        .irq_request, .irq_vector, .vector_call, .return_from_isr,
        .flag_clear(4'h0)
    );
    core_model core
    (
        .aclk, .aresetn, .irq_request, .vector_call, .return_from_isr,
        .take_en(take), .ret_req
    );

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic hang;
        chk("timeout", 0, 1);
        close_out();
    endtask

    // one transfer; w selects write, d is write data or expected read data
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_bready  <= w;
        s_axi_arvalid <= !w;
        s_axi_rready  <= !w;
        repeat (20)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid || s_axi_rvalid)
            begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                chk("resp", r, w ? s_axi_bresp : s_axi_rresp);
                if (!w)
                    chk("rdata", d, s_axi_rdata);
                return;
            end
        end
        hang();
    endtask

    task automatic wait_req(input logic v, input int lim);
        repeat (lim)
        begin
            @(posedge aclk);
            if (irq_request === v)
                return;
        end
        hang();
    endtask

    task automatic quiet(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            chk("quiet", 0, irq_request);
        end
    endtask

    task automatic ret;
        @(posedge aclk);
        ret_req <= 1'b1;
        @(posedge aclk);
        ret_req <= 1'b0;
    endtask

    // offer seen, vector compared, then the core's call clears it
    task automatic served(input logic [15:0] e);
        wait_req(1'b1, 12);
        chk("irq_vector", e, irq_vector);
        wait_req(1'b0, 12);
    endtask

    task automatic t_regs;
        bus(1'b0, ADDR_ENABLE, 8'h00, RESP_OKAY);
        bus(1'b0, ADDR_LEVEL, 8'h80, RESP_OKAY);
        bus(1'b0, ADDR_STATUS, 8'h00, RESP_OKAY);
        bus(1'b0, 8'h10, 8'h00, RESP_SLVERR);
        bus(1'b1, 8'h10, 8'h00, RESP_SLVERR);
        bus(1'b1, ADDR_LEVEL, 8'h7F, RESP_OKAY);
        bus(1'b0, ADDR_LEVEL, 8'hFF, RESP_OKAY);
        bus(1'b1, ADDR_ENABLE, 8'h5A, RESP_OKAY);
        bus(1'b0, ADDR_ENABLE, 8'h5A, RESP_OKAY);
        bus(1'b1, ADDR_PEND, 8'h10, RESP_OKAY);
        bus(1'b0, ADDR_PEND, 8'h10, RESP_OKAY);
        bus(1'b1, ADDR_PEND, 8'h00, RESP_OKAY);
        bus(1'b1, ADDR_LEVEL, 8'h00, RESP_OKAY);
    endtask

    // per source: gate off, own enable off, then both on
    task automatic t_gates;
        logic [7:0]  m;
        logic [15:0] v;
        for (int i = 0; i < 7; i++)
        begin
            m = 8'h01 << i;
            v = VEC_BASE + 16'(VEC_STRIDE * i);
            bus(1'b1, ADDR_ENABLE, 8'h7F, RESP_OKAY);
            src[i] <= 1'b1;
            if (i < 4)
            begin
                @(posedge aclk);
                src[i] <= 1'b0;
            end
            quiet(8);
            bus(1'b1, ADDR_ENABLE, 8'hFF & ~m, RESP_OKAY);
            quiet(6);
            bus(1'b1, ADDR_ENABLE, 8'hFF, RESP_OKAY);
            served(v);
            ret();
            if (i >= 4)
            begin
                served(v);
                src[i] <= 1'b0;
                ret();
            end
            quiet(6);
        end
    endtask

    // timer 2 high level, uart0 and index 7 low
    task automatic t_prio;
        bus(1'b1, ADDR_LEVEL, 8'h20, RESP_OKAY);
        take <= 1'b0;
        src[4] <= 1'b1;
        timer2_low_overflow <= 1'b1;
        ext_src_flags <= 10'h001;
        wait_req(1'b1, 3);
        repeat (4) @(posedge aclk);
        chk("stalled vector", 16'h002B, irq_vector);
        take <= 1'b1;
        wait_req(1'b0, 12);
        timer2_low_overflow <= 1'b0;
        bus(1'b0, ADDR_STATUS, 8'h55, RESP_OKAY);
        quiet(6);
        ret();
        served(16'h0023);
        src[5] <= 1'b1;
        served(16'h002B);
        src[5] <= 1'b0;
        ret();
        quiet(6);
        ret();
        served(16'h0023);
        src[4] <= 1'b0;
        ret();
        served(16'h003B);
        ext_src_flags <= 10'h000;
        ret();
        quiet(6);
    endtask

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, ret_req, timer2_low_overflow} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {src, ext_src_flags} = '0;
        take = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_gates();
        t_prio();
        close_out();
    end
endmodule
`default_nettype wire
